// File: rtl/flash_host_cfg.svh
// Constants for the flash host controller: command codes, status bit
// positions, identify addresses and bus cycle timing counts.
// Assumes a 100 MHz ref_clk and an asynchronous 16-bit NOR flash part.
`ifndef FLASH_HOST_CFG_SVH
`define FLASH_HOST_CFG_SVH

`define CMD_PROGRAM        8'h40
`define CMD_PROGRAM_ALT    8'h10
`define CMD_ERASE_SETUP    8'h20
`define CMD_CLEAR_STATUS   8'h50
`define CMD_READ_STATUS    8'h70
`define CMD_IDENTIFY       8'h90
`define CMD_SUSPEND        8'hB0
`define CMD_CONFIRM        8'hD0
`define CMD_READ_ARRAY     8'hFF

`define ST_READY           7
`define ST_ERASE_SUSP      6
`define ST_ERASE_FAIL      5
`define ST_PROG_FAIL       4
`define ST_SUPPLY_FAULT    3
`define ST_PROG_SUSP       2
`define ST_BLOCK_LOCKED    1
`define ST_RESERVED        0

`define ID_MAKER_ADDR      20'h00000
`define ID_PART_ADDR       20'h00001

// Strobe timing in ns and derived cycle counts at 100 MHz
`define CLK_PERIOD_NS      10
`define T_STROBE_NS        90
`define T_RECOVER_NS       30
`define STROBE_CYCLES      ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RECOVER_CYCLES     ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// File: rtl/flash_host_pkg.sv
// Types shared by the flash host controller files.
// Assumes the constants header is included by the design files.
package flash_host_pkg;

  // User-side operation requests
  typedef enum logic [2:0] {
    OP_READ_ARRAY,
    OP_READ_STATUS,
    OP_IDENTIFY,
    OP_PROGRAM,
    OP_ERASE,
    OP_SUSPEND,
    OP_RESUME,
    OP_CLEAR_STATUS
  } op_t;

  // Device mode as the host tracks it
  typedef enum logic [1:0] {
    DEV_READ_ARRAY,
    DEV_READ_STATUS,
    DEV_IDENTIFY
  } dev_mode_t;

endpackage : flash_host_pkg

// File: rtl/flash_bus_cycle.sv
// Single asynchronous bus cycle engine: one write or one read of the flash.
// Assumes the flash data input has already passed a two-stage synchroniser.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_bus_cycle
  import flash_host_pkg::*;
#(
  parameter int STROBE_CYC  = `STROBE_CYCLES,
  parameter int RECOVER_CYC = `RECOVER_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        start,
  input  wire logic        is_write,
  input  wire logic [19:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic [15:0] dq_sync,
  output logic             done,
  output logic [15:0]      rdata_q,
  output logic [19:0]      flash_addr_q,
  output logic             chip_select_n_q,
  output logic             output_enable_n_q,
  output logic             write_enable_n_q,
  output logic [15:0]      dq_out_q,
  output logic             dq_oe_q
);

  // Read data crosses two synchroniser flops, so the strobe must stand at
  // least three cycles before the capture edge sees the driven value
  initial begin
    if (STROBE_CYC < 3 || STROBE_CYC > 255 || RECOVER_CYC < 1 || RECOVER_CYC > 255)
      $error("flash_bus_cycle: cycle counts out of range");
  end

  typedef enum logic [1:0] {CYC_IDLE, CYC_STROBE, CYC_RECOVER} cyc_state_t;

  cyc_state_t state_q;
  logic [7:0] cnt_q;
  logic       wr_q;

  // Count end of a phase
  wire logic strobe_end  = (state_q == CYC_STROBE) && (cnt_q == 8'(STROBE_CYC - 1));
  wire logic recover_end = (state_q == CYC_RECOVER) && (cnt_q == 8'(RECOVER_CYC - 1));
  assign done = clk_en && recover_end;

  // Cycle sequencer: strobe low for STROBE_CYC, then recovery with strobes high
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= CYC_IDLE;
      cnt_q   <= 8'h00;
      wr_q    <= 1'b0;
    end else if (clk_en) begin
      case (state_q)
        CYC_IDLE: begin
          cnt_q <= 8'h00;
          if (start) begin
            state_q <= CYC_STROBE;
            wr_q    <= is_write;
          end
        end
        CYC_STROBE: begin
          cnt_q <= strobe_end ? 8'h00 : cnt_q + 8'h01;
          if (strobe_end) state_q <= CYC_RECOVER;
        end
        CYC_RECOVER: begin
          cnt_q <= cnt_q + 8'h01;
          if (recover_end) state_q <= CYC_IDLE;
        end
        default: state_q <= CYC_IDLE;
      endcase
    end
  end

  // Pin drive: chip select and one strobe fall together each cycle
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      chip_select_n_q   <= 1'b1;
      output_enable_n_q <= 1'b1;
      write_enable_n_q  <= 1'b1;
      dq_oe_q           <= 1'b0;
      dq_out_q          <= 16'h0000;
      flash_addr_q      <= 20'h00000;
      rdata_q           <= 16'h0000;
    end else if (clk_en) begin
      if (state_q == CYC_IDLE && start) begin
        flash_addr_q      <= addr;
        dq_out_q          <= wdata;
        dq_oe_q           <= is_write;
        chip_select_n_q   <= 1'b0;
        output_enable_n_q <= is_write;
        write_enable_n_q  <= !is_write;
      end else if (strobe_end) begin
        chip_select_n_q   <= 1'b1;
        output_enable_n_q <= 1'b1;
        write_enable_n_q  <= 1'b1;
        if (!wr_q) rdata_q <= dq_sync;
      end else if (recover_end) begin
        dq_oe_q <= 1'b0;
      end
    end
  end

  AST_STROBE_WIDTH: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && $fell(chip_select_n_q) |-> !chip_select_n_q [*3])
    else $error("chip select pulse too short");
  AST_ONE_STROBE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !(!output_enable_n_q && !write_enable_n_q))
    else $error("read and write strobes both low");
  AST_DRIVE_ON_WRITE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    !write_enable_n_q |-> dq_oe_q)
    else $error("write strobe without data drive");
  COV_WRITE_CYCLE: cover property (@(posedge ref_clk) $fell(write_enable_n_q));
  COV_READ_CYCLE: cover property (@(posedge ref_clk) $fell(output_enable_n_q));

endmodule : flash_bus_cycle

// File: rtl/flash_host.sv
// Host-side controller for an asynchronous NOR flash: turns user operation
// requests into command write and read cycles and tracks the device mode.
// Assumes the flash pins are joined by the bench; data is a three-signal pin.
`timescale 1ns/1ps
`include "flash_host_cfg.svh"
module flash_host
  import flash_host_pkg::*;
#(
  parameter int STROBE_CYC  = `STROBE_CYCLES,
  parameter int RECOVER_CYC = `RECOVER_CYCLES
) (
  input  wire logic        ref_clk,
  input  wire logic        sys_rst,
  input  wire logic        clk_en,
  input  wire logic        req_valid,
  output logic             req_ready,
  input  wire op_t         req_op,
  input  wire logic [19:0] req_addr,
  input  wire logic [15:0] req_wdata,
  output logic             rsp_valid_q,
  output logic [15:0]      rsp_data_q,
  output logic             busy_q,
  output logic [19:0]      flash_addr,
  output logic             chip_select_n,
  output logic             output_enable_n,
  output logic             write_enable_n,
  output logic             reset_powerdown_n,
  output logic [15:0]      data_lines_out,
  output logic             data_lines_oe,
  input  wire logic [15:0] data_lines_in
);

  //////////////////////////////////////////////////////////////////////////
  // Declarations and helpers

  typedef enum logic [2:0] {
    H_IDLE, H_CMD1, H_CMD2, H_READ, H_DONE
  } host_state_t;

  host_state_t state_q;
  op_t         op_q;
  dev_mode_t   mode_q;
  logic [19:0] addr_q;
  logic [15:0] wdata_q;
  logic [15:0] dq_meta_q;
  logic [15:0] dq_sync_q;
  logic        cyc_start;
  logic        cyc_write;
  logic [19:0] cyc_addr;
  logic [15:0] cyc_wdata;
  logic        cyc_done;
  logic [15:0] cyc_rdata;
  logic        prog_busy_q;
  logic        erase_busy_q;
  logic        suspended_q;

  // Command code for the first write of an operation
  function automatic logic [7:0] first_code(input op_t op);
    case (op)
      OP_READ_ARRAY:   first_code = `CMD_READ_ARRAY;
      OP_READ_STATUS:  first_code = `CMD_READ_STATUS;
      OP_IDENTIFY:     first_code = `CMD_IDENTIFY;
      OP_PROGRAM:      first_code = `CMD_PROGRAM;
      OP_ERASE:        first_code = `CMD_ERASE_SETUP;
      OP_SUSPEND:      first_code = `CMD_SUSPEND;
      OP_RESUME:       first_code = `CMD_CONFIRM;
      OP_CLEAR_STATUS: first_code = `CMD_CLEAR_STATUS;
      default:         first_code = `CMD_READ_ARRAY;
    endcase
  endfunction : first_code

  //////////////////////////////////////////////////////////////////////////
  // Data pin synchroniser: two flops before any logic reads it

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dq_meta_q <= 16'h0000;
      dq_sync_q <= 16'h0000;
    end else if (clk_en) begin
      dq_meta_q <= data_lines_in;
      dq_sync_q <= dq_meta_q;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Request filtering while the write sequencer runs

  // Busy device takes only suspend, or a status poll that writes no command;
  // suspended device only array reads, status reads and resume
  wire logic seq_running = (prog_busy_q || erase_busy_q) && !suspended_q;
  wire logic op_allowed  =
      seq_running ? (req_op == OP_SUSPEND || req_op == OP_READ_STATUS) :
      suspended_q ? (req_op == OP_READ_ARRAY || req_op == OP_READ_STATUS ||
                     req_op == OP_RESUME) :
      (req_op != OP_SUSPEND && req_op != OP_RESUME);
  wire logic two_writes  = (op_q == OP_PROGRAM) || (op_q == OP_ERASE);
  wire logic read_after  = (op_q == OP_READ_ARRAY) || (op_q == OP_READ_STATUS) ||
                           (op_q == OP_IDENTIFY);
  // A mode already in force needs no new command write
  wire logic mode_hit    = (op_q == OP_READ_ARRAY  && mode_q == DEV_READ_ARRAY) ||
                           (op_q == OP_READ_STATUS && mode_q == DEV_READ_STATUS) ||
                           (op_q == OP_IDENTIFY    && mode_q == DEV_IDENTIFY);
  assign req_ready = (state_q == H_IDLE) && op_allowed;
  wire logic accept = clk_en && req_valid && req_ready;
  wire logic ready_bit = cyc_rdata[`ST_READY];
  wire logic susp_bits = cyc_rdata[`ST_PROG_SUSP] | cyc_rdata[`ST_ERASE_SUSP];

  // Bus cycle selection
  assign cyc_start = (state_q == H_CMD1 || state_q == H_CMD2 || state_q == H_READ);
  assign cyc_write = (state_q != H_READ);
  assign cyc_addr  = (state_q == H_CMD1) ? 20'h00000 : addr_q;
  assign cyc_wdata = (state_q == H_CMD2) ?
                     ((op_q == OP_ERASE) ? {8'h00, `CMD_CONFIRM} : wdata_q) :
                     {8'h00, first_code(op_q)};

  //////////////////////////////////////////////////////////////////////////
  // Host sequencer

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q <= H_IDLE;
      op_q    <= OP_READ_ARRAY;
      addr_q  <= 20'h00000;
      wdata_q <= 16'h0000;
    end else if (clk_en) begin
      case (state_q)
        H_IDLE: if (accept) begin
          op_q    <= req_op;
          addr_q  <= req_addr;
          wdata_q <= req_wdata;
          state_q <= H_CMD1;
        end
        H_CMD1: begin
          if (mode_hit) state_q <= H_READ;
          else if (cyc_done) state_q <= two_writes ? H_CMD2 :
                                        read_after ? H_READ : H_DONE;
        end
        H_CMD2: if (cyc_done) state_q <= H_DONE;
        H_READ: if (cyc_done) state_q <= H_DONE;
        H_DONE: state_q <= H_IDLE;
        default: state_q <= H_IDLE;
      endcase
    end
  end

  // Device mode tracking: power-up and clear status leave read array
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mode_q <= DEV_READ_ARRAY;
    end else if (clk_en && state_q == H_CMD1 && cyc_done && !mode_hit) begin
      case (op_q)
        OP_IDENTIFY:     mode_q <= DEV_IDENTIFY;
        OP_READ_ARRAY:   mode_q <= DEV_READ_ARRAY;
        OP_CLEAR_STATUS: mode_q <= DEV_READ_ARRAY;
        default:         mode_q <= DEV_READ_STATUS;
      endcase
    end
  end

  // Sequencer activity as seen by the host; every status poll is its own
  // strobe-framed read so the device relatches fresh status
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      prog_busy_q  <= 1'b0;
      erase_busy_q <= 1'b0;
      suspended_q  <= 1'b0;
      busy_q       <= 1'b0;
    end else if (clk_en) begin
      if (state_q == H_CMD2 && cyc_done) begin
        prog_busy_q  <= (op_q == OP_PROGRAM);
        erase_busy_q <= (op_q == OP_ERASE);
      end else if (state_q == H_CMD1 && cyc_done && op_q == OP_SUSPEND) begin
        suspended_q  <= 1'b1;
      end else if (state_q == H_CMD1 && cyc_done && op_q == OP_RESUME) begin
        suspended_q  <= 1'b0;
      end else if (state_q == H_READ && cyc_done && op_q == OP_READ_STATUS &&
                   ready_bit) begin
        suspended_q  <= susp_bits;
        // A halted operation keeps its busy record for the resume
        if (!susp_bits) begin
          prog_busy_q  <= 1'b0;
          erase_busy_q <= 1'b0;
        end
      end
      busy_q <= seq_running;
    end
  end

  // Response: status reads masked to low byte with reserved bit zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rsp_valid_q <= 1'b0;
      rsp_data_q  <= 16'h0000;
    end else if (clk_en) begin
      rsp_valid_q <= (state_q == H_READ) && cyc_done;
      if ((state_q == H_READ) && cyc_done)
        rsp_data_q <= (op_q == OP_READ_STATUS) ?
                      {8'h00, cyc_rdata[7:1], 1'b0} : cyc_rdata;
    end
  end

  // Reset/power-down follows system reset so the array is protected
  always_ff @(posedge ref_clk) begin
    if (sys_rst) reset_powerdown_n <= 1'b0;
    else         reset_powerdown_n <= 1'b1;
  end

  //////////////////////////////////////////////////////////////////////////
  // Bus cycle engine

  flash_bus_cycle #(
    .STROBE_CYC  (STROBE_CYC),
    .RECOVER_CYC (RECOVER_CYC)
  ) u_cycle (
    .ref_clk           (ref_clk),
    .sys_rst           (sys_rst),
    .clk_en            (clk_en),
    .start             (cyc_start && !(state_q == H_CMD1 && mode_hit)),
    .is_write          (cyc_write),
    .addr              (cyc_addr),
    .wdata             (cyc_wdata),
    .dq_sync           (dq_sync_q),
    .done              (cyc_done),
    .rdata_q           (cyc_rdata),
    .flash_addr_q      (flash_addr),
    .chip_select_n_q   (chip_select_n),
    .output_enable_n_q (output_enable_n),
    .write_enable_n_q  (write_enable_n),
    .dq_out_q          (data_lines_out),
    .dq_oe_q           (data_lines_oe)
  );

  //////////////////////////////////////////////////////////////////////////
  // Checks

  AST_BUSY_FILTER: assert property (@(posedge ref_clk) disable iff (sys_rst)
    prog_busy_q && !suspended_q && $fell(write_enable_n)
      |-> data_lines_out[7:0] == `CMD_SUSPEND)
    else $error("command other than suspend written during program");
  AST_ERASE_FILTER: assert property (@(posedge ref_clk) disable iff (sys_rst)
    erase_busy_q && !suspended_q && $fell(write_enable_n)
      |-> data_lines_out[7:0] == `CMD_SUSPEND)
    else $error("command other than suspend written during erase");
  AST_BUSY_ACCEPT: assert property (@(posedge ref_clk) disable iff (sys_rst)
    seq_running && accept |-> req_op inside {OP_SUSPEND, OP_READ_STATUS})
    else $error("busy sequencer accepted wrong op");
  AST_RESET_PIN: assert property (@(posedge ref_clk)
    sys_rst |=> !reset_powerdown_n)
    else $error("reset_powerdown_n not low after reset");
  AST_STATUS_HIGH_ZERO: assert property (@(posedge ref_clk) disable iff (sys_rst)
    rsp_valid_q && op_q == OP_READ_STATUS |-> rsp_data_q[15:8] == 8'h00
      && rsp_data_q[`ST_RESERVED] == 1'b0)
    else $error("status high byte or reserved bit nonzero");
  AST_CLEAR_MODE: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && state_q == H_CMD1 && cyc_done && op_q == OP_CLEAR_STATUS
      |=> mode_q == DEV_READ_ARRAY)
    else $error("clear status did not return to read array");
  AST_BUSY_AFTER_CONFIRM: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && state_q == H_CMD2 && cyc_done |=> seq_running)
    else $error("sequencer not busy after confirm");
  AST_SUSPEND_ONLY: assert property (@(posedge ref_clk) disable iff (sys_rst)
    suspended_q && accept |-> req_op inside {OP_READ_ARRAY, OP_READ_STATUS,
      OP_RESUME})
    else $error("suspended device given illegal op");
  AST_RESP_TIMING: assert property (@(posedge ref_clk) disable iff (sys_rst)
    clk_en && state_q == H_READ && cyc_done |=> rsp_valid_q)
    else $error("read response missing");
  COV_PROGRAM: cover property (@(posedge ref_clk) accept && req_op == OP_PROGRAM);
  COV_ERASE: cover property (@(posedge ref_clk) accept && req_op == OP_ERASE);
  COV_POLL: cover property (@(posedge ref_clk) rsp_valid_q && op_q == OP_READ_STATUS);

endmodule : flash_host

// File: tb/flash_dev_model.sv
// Behavioural flash device: command decoder, status register and identify codes.
// Assumes host-registered strobes; it also resolves the shared data lines.
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MAKER_CODE = 16'h1A2B, // Arbitrary value
  parameter logic [15:0] PART_CODE  = 16'h3C4D  // Arbitrary value
) (
  input  wire logic [19:0] flash_addr,
  input  wire logic        chip_select_n,
  input  wire logic        output_enable_n,
  input  wire logic        write_enable_n,
  input  wire logic        reset_powerdown_n,
  input  wire logic [15:0] host_dq,
  input  wire logic        host_oe,
  input  wire logic        supply_ok,
  input  wire logic        write_protect_n,
  input  wire logic        fail_next,
  input  wire logic [3:0]  busy_polls,
  output logic [15:0]      dq
);
  logic [15:0] mem [256];
  logic [15:0] last, dev_val, tgt_d;
  logic [7:0]  stat_q, tgt_a;
  logic [3:0]  cnt;
  logic [1:0]  mode, pend, op;
  logic        psusp, esusp, efail, pfail, sfault, locked;
  wire  [7:0]  cmd = host_dq[7:0];
  wire         wr_n = chip_select_n | write_enable_n;
  wire         rd_n = chip_select_n | output_enable_n;
  wire         dev_oe = !rd_n && write_enable_n && reset_powerdown_n;
////////////////////////////////////////
  // Sequencer idle or halted
  function automatic logic rdy();
    return op == 2'd0 || psusp || esusp;
  endfunction : rdy

  // Launch program or erase, or abort with a fault flag
  task automatic start(input logic [1:0] k);
    mode = 2'd1;
    if (!supply_ok) sfault = 1'b1;
    else if (!write_protect_n && flash_addr[19]) locked = 1'b1;
    else {op, cnt, tgt_a, tgt_d} = {k, busy_polls, flash_addr[7:0], host_dq};
  endtask : start

  // Erased array at power-up; power-down clears sequencer and status
  initial for (int i = 0; i < 256; i++) mem[i] = 16'hFFFF;
  always @(negedge reset_powerdown_n) begin
    {mode, pend, op, cnt, psusp, esusp, efail, pfail, sfault, locked} = '0;
    stat_q = 8'h80;
  end

  // Command decode at the rising write strobe
  always @(posedge wr_n) if (reset_powerdown_n) begin
    if (pend != 2'd0) begin
      if (pend == 2'd1 || cmd == 8'hD0) start(pend);
      pend = 2'd0;
    end else if (!rdy()) begin
      if (cmd == 8'hB0 && op == 2'd1) psusp = 1'b1;
      else if (cmd == 8'hB0) esusp = 1'b1;
    end else if (psusp || esusp) begin
      if (cmd == 8'hD0) {psusp, esusp, mode} = 4'h1;
      else if (cmd == 8'hFF || cmd == 8'h70) mode = {1'b0, cmd == 8'h70};
    end else begin
      case (cmd)
        8'hFF: mode = 2'd0;
        8'h70: mode = 2'd1;
        8'h90: mode = 2'd2;
        8'h50: {mode, efail, pfail, sfault, locked} = '0;
        8'h40, 8'h10: {mode, pend} = 4'h5;
        8'h20: {mode, pend} = 4'h6;
        default: ;
      endcase
    end
  end

  // Status captured at the later falling read strobe, held for the cycle
  always @(negedge rd_n) if (mode == 2'd1 && write_enable_n) begin
    if (!rdy() && cnt != 4'h0) cnt = cnt - 4'h1;
    else if (!rdy()) begin
      if (fail_next && op == 2'd1) pfail = 1'b1;
      else if (fail_next) efail = 1'b1;
      else if (op == 2'd1) mem[tgt_a] = mem[tgt_a] & tgt_d;
      op = 2'd0;
    end
    stat_q = {rdy(), esusp, efail, pfail, sfault, psusp, locked, 1'b0};
  end

  // Read data per mode; released lines show the inverse of the last value
  assign dev_val = mode == 2'd1 ? {8'h00, stat_q} :
                   mode == 2'd0 ? mem[flash_addr[7:0]] :
                   flash_addr == 20'h00001 ? PART_CODE : MAKER_CODE;
  assign dq = host_oe ? host_dq : dev_oe ? dev_val : ~last;
  always @(host_oe, host_dq, dev_oe, dev_val) if (host_oe || dev_oe) last = host_oe ? host_dq : dev_val;
endmodule : flash_dev_model

// File: tb/tb.sv
// Top bench: flash host controller driving the behavioural flash device.
// Assumes shortened strobe counts; every wait is bounded.
`timescale 1ns/1ps
`define CHK(what, exp, got) \
  begin \
    num_checks++; \
    if ((got) !== (exp)) begin \
      n_mismatch++; \
      $display("CHECK FAILED %s exp %h got %h", what, exp, got); \
    end \
  end
module tb
  import flash_host_pkg::*;
;
  localparam logic [15:0] MAKER = 16'h1A2B; // Arbitrary value
  localparam logic [15:0] PART  = 16'h3C4D; // Arbitrary value
  logic        ref_clk = 1'b0;
  logic        sys_rst = 1'b1;
  logic        req_valid = 1'b0;
  op_t         req_op = OP_READ_ARRAY;
  logic [19:0] req_addr = 20'h0;
  logic [15:0] req_wdata = 16'h0;
  logic        supply_ok = 1'b1;
  logic        write_protect_n = 1'b1;
  logic        fail_next = 1'b0;
  logic [3:0]  busy_polls = 4'h0;
  logic        req_ready, rsp_valid_q, busy_q, chip_select_n, output_enable_n;
  logic        write_enable_n, reset_powerdown_n, data_lines_oe;
  logic [15:0] rsp_data_q, data_lines_out, data_lines_in, rd;
  logic [19:0] flash_addr;
  int          num_checks = 0;
  int          n_mismatch = 0;
  logic [15:0] fexp [4] = '{16'h00A0, 16'h0090, 16'h0088, 16'h0082};
////////////////////////////////////////
  // Controller with short strobes, and the device it drives
  flash_host #(.STROBE_CYC(3), .RECOVER_CYC(1)) flash_host_i (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .clk_en(1'b1), .req_valid(req_valid),
    .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr),
    .req_wdata(req_wdata), .rsp_valid_q(rsp_valid_q), .rsp_data_q(rsp_data_q),
    .busy_q(busy_q), .flash_addr(flash_addr), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .reset_powerdown_n(reset_powerdown_n), .data_lines_out(data_lines_out),
    .data_lines_oe(data_lines_oe), .data_lines_in(data_lines_in));
  flash_dev_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) flash_dev_model_i (
    .flash_addr(flash_addr), .chip_select_n(chip_select_n),
    .output_enable_n(output_enable_n), .write_enable_n(write_enable_n),
    .reset_powerdown_n(reset_powerdown_n), .host_dq(data_lines_out),
    .host_oe(data_lines_oe), .supply_ok(supply_ok),
    .write_protect_n(write_protect_n), .fail_next(fail_next),
    .busy_polls(busy_polls), .dq(data_lines_in));

  always #5 ref_clk = ~ref_clk;
////////////////////////////////////////
  // Counts and verdict, then stop
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : close_out

  // A wait that ran out of cycles
  task automatic give_up();
    n_mismatch++;
    $display("CHECK FAILED handshake exp done got timeout");
    close_out();
  endtask : give_up

  // Present an operation and wait until the controller can take it
  task automatic wait_ready(input op_t op, input logic v);
    int n;
    req_op <= op;
    req_valid <= v;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 300);
    if (n >= 300) give_up();
  endtask : wait_ready

  // One user operation; reads return the response data
  task automatic do_op(input op_t op, input logic [19:0] a, input logic [15:0] d,
                       output logic [15:0] r);
    int n;
    r = 16'h0000;
    req_addr <= a;
    req_wdata <= d;
    wait_ready(op, 1'b1);
    req_valid <= 1'b0;
    @(posedge ref_clk);
    if (op inside {OP_READ_ARRAY, OP_READ_STATUS, OP_IDENTIFY}) begin
      n = 0;
      while (rsp_valid_q !== 1'b1 && n < 300) begin
        @(posedge ref_clk);
        n++;
      end
      if (n >= 300) give_up();
      r = rsp_data_q;
    end
  endtask : do_op

  // Controller must not offer this operation now
  task automatic refused(input op_t op);
    req_op <= op;
    repeat (2) @(posedge ref_clk);
    `CHK("refused", 1'b0, req_ready)
  endtask : refused

  // Fresh status reads until ready, then compare
  task automatic poll(input logic [15:0] exp);
    logic [15:0] r;
    int n;
    n = 0;
    do begin
      do_op(OP_READ_STATUS, 20'h0, 16'h0000, r);
      n++;
    end while (r[7] !== 1'b1 && n < 12);
    `CHK("status", exp, r)
    @(posedge ref_clk);
    `CHK("busy", 1'b0, busy_q)
  endtask : poll
////////////////////////////////////////
  // Main sequence
  initial begin
    repeat (4) @(posedge ref_clk);
    `CHK("powerdown", 1'b0, reset_powerdown_n)
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    do_op(OP_READ_ARRAY, 20'h00010, 16'h0000, rd);
    `CHK("array", 16'hFFFF, rd)
    for (int k = 0; k < 2; k++) begin
      do_op(OP_IDENTIFY, 20'(k), 16'h0000, rd);
      `CHK("ident", k ? PART : MAKER, rd)
    end
    busy_polls <= 4'h3;
    do_op(OP_PROGRAM, 20'h00010, 16'h5A3C, rd);
    wait_ready(OP_SUSPEND, 1'b0);
    `CHK("busy", 1'b1, busy_q)
    refused(OP_READ_ARRAY);
    poll(16'h0080);
    do_op(OP_READ_ARRAY, 20'h00010, 16'h0000, rd);
    `CHK("array", 16'h5A3C, rd)
    do_op(OP_READ_ARRAY, 20'h00011, 16'h0000, rd);
    `CHK("array", 16'hFFFF, rd)
    for (int k = 0; k < 2; k++) begin
      busy_polls <= 4'h4;
      do_op(k ? OP_ERASE : OP_PROGRAM, 20'h00020, 16'h0F0F, rd);
      wait_ready(OP_SUSPEND, 1'b0);
      refused(OP_IDENTIFY);
      do_op(OP_SUSPEND, 20'h0, 16'h0000, rd);
      do_op(OP_READ_STATUS, 20'h0, 16'h0000, rd);
      `CHK("suspended", k ? 16'h00C0 : 16'h0084, rd)
      refused(OP_ERASE);
      do_op(OP_RESUME, 20'h0, 16'h0000, rd);
      poll(16'h0080);
    end
    for (int k = 0; k < 4; k++) begin
      supply_ok <= k != 2;
      write_protect_n <= k != 3;
      fail_next <= k < 2;
      busy_polls <= 4'h0;
      do_op(k == 1 ? OP_PROGRAM : OP_ERASE, 20'h80040, 16'h1234, rd);
      poll(fexp[k]);
      do_op(OP_CLEAR_STATUS, 20'h0, 16'h0000, rd);
      do_op(OP_READ_STATUS, 20'h0, 16'h0000, rd);
      `CHK("cleared", 16'h0080, rd)
    end
    sys_rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    `CHK("powerdown", 1'b0, reset_powerdown_n)
    sys_rst <= 1'b0;
    @(posedge ref_clk);
    do_op(OP_READ_ARRAY, 20'h00010, 16'h0000, rd);
    `CHK("array", 16'h5A3C, rd)
    close_out();
  end
endmodule : tb
